// file: hdl/ubtc_pkg.sv
// Constants, field positions and state types for the UART serial core.
// Assumes a single 50 MHz system clock feeding the baud logic.
package ubtc_pkg;

	// ****************************************************************
	// Host register offsets
	// ****************************************************************
	localparam logic [2:0] OFS_DATA = 3'h0; // Holding regs / divisor low
	localparam logic [2:0] OFS_IER = 3'h1; // Interrupt enable / divisor high
	localparam logic [2:0] OFS_ISR_FCR = 3'h2; // Read source, write FIFO ctrl
	localparam logic [2:0] OFS_LCR = 3'h3;
	localparam logic [2:0] OFS_MCR = 3'h4;
	localparam logic [2:0] OFS_LSR = 3'h5;
	localparam logic [2:0] OFS_SCR = 3'h7;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int MCR_PRESC_BIT = 7;
	localparam int LCR_STOP_BIT = 2;
	localparam int LCR_PEN_BIT = 3;
	localparam int LCR_EVEN_BIT = 4;
	localparam int LCR_STICK_BIT = 5;
	localparam int LCR_DLAB_BIT = 7;
	localparam int FCR_EN_BIT = 0;
	localparam int FCR_RXRST_BIT = 1;
	localparam int FCR_TXRST_BIT = 2;
	localparam int IER_RX_BIT = 0;
	localparam int IER_TX_BIT = 1;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] DIV_LO_RST = 8'h01;
	localparam logic [7:0] DIV_HI_RST = 8'h00;
	localparam logic [7:0] REG_RST = 8'h00;

	// ****************************************************************
	// Timing figures
	// ****************************************************************
	localparam int PRESC_DIV = 4;
	localparam logic [1:0] PRESC_LAST = 2'(PRESC_DIV - 1);
	localparam int TICKS_PER_BIT = 16;
	localparam int TICKS_TO_CENTRE = 8;
	localparam logic [3:0] TICK_LAST = 4'(TICKS_PER_BIT - 1);
	localparam logic [3:0] TICK_HALF_LAST = 4'(TICKS_TO_CENTRE - 1);
	localparam int TO_WORDS = 4;
	localparam int TO_EXTRA_BITS = 12;
	localparam int MIN_DATA_BITS = 5;

	// ****************************************************************
	// FIFO trigger levels and interrupt source codes
	// ****************************************************************
	localparam int TRIG_L0 = 1;
	localparam int TRIG_L1 = 4;
	localparam int TRIG_L2 = 8;
	localparam int TRIG_L3 = 14;
	localparam logic [3:0] ISR_NONE = 4'h1;
	localparam logic [3:0] ISR_TX = 4'h2;
	localparam logic [3:0] ISR_RX = 4'h4;
	localparam logic [3:0] ISR_TIMEOUT = 4'hC;

	// ****************************************************************
	// State types
	// ****************************************************************
	typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} ubtc_txst_t;
	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} ubtc_rxst_t;

endpackage

// file: hdl/ubtc_fifo_if.sv
// Interface between the serial core and its W-bit FIFOs.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
`default_nettype none
interface ubtc_fifo_if
	#(parameter int W = 8, parameter int DEPTH = 16);
	localparam int CW = $clog2(DEPTH + 1);
	logic push;
	logic pop;
	logic clear;
	logic [W-1:0] wdata;
	logic [W-1:0] rdata;
	logic [CW-1:0] count;
	logic full;
	logic empty;
	modport user (output push, output pop, output clear, output wdata,
		input rdata, input count, input full, input empty);
	modport store (input push, input pop, input clear, input wdata,
		output rdata, output count, output full, output empty);
endinterface
`default_nettype wire

// file: hdl/ubtc_fifo.sv
// Circular W-bit FIFO with occupancy count, used for transmit (8 bits) and receive (11 bits).
// Ignores a push when full and a pop when empty.
`timescale 1ns/1ns
`default_nettype none
module ubtc_fifo
	#(parameter int W = 8, parameter int DEPTH = 16)
(
	input wire logic clk,
	input wire logic rst,
	ubtc_fifo_if.store f
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [CW-1:0] count_q;
	logic do_push;
	logic do_pop;

	// Guarded handshakes
	assign do_push = f.push & ~f.full;
	assign do_pop = f.pop & ~f.empty;
	assign f.full = (count_q == CW'(DEPTH));
	assign f.empty = (count_q == '0);
	assign f.count = count_q;
	assign f.rdata = mem_q[rd_ptr_q];

	// Storage array
	always_ff @(posedge clk)
	begin
		if (do_push)
			mem_q[wr_ptr_q] <= f.wdata;
	end

	// Pointers and count, clear wins
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end
		else if (f.clear)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (do_push)
				wr_ptr_q <= wr_ptr_q + 1'b1;
			if (do_pop)
				rd_ptr_q <= rd_ptr_q + 1'b1;
			if (do_push & ~do_pop)
				count_q <= count_q + 1'b1;
			else if (do_pop & ~do_push)
				count_q <= count_q - 1'b1;
		end
	end
endmodule // ubtc_fifo
`default_nettype wire

// file: hdl/ubtc_core.sv
// Serial core: host register set, baud generator, transmitter, receiver.
// Assumes host strobes and serial input are asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module ubtc_core
	import ubtc_pkg::*;
	#(parameter int FIFO_DEPTH = 16)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [2:0] addr,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe_n,
	input wire logic serial_in,
	output logic serial_out,
	output logic int_out
);
	localparam int BUS_W = 14;
	localparam int CW = $clog2(FIFO_DEPTH + 1);
	localparam int TO_W = 11;

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Trigger level from a two-bit select
	function automatic logic [CW-1:0] trig_level(input logic [1:0] sel);
		unique case (sel)
			2'h0: trig_level = CW'(TRIG_L0);
			2'h1: trig_level = CW'(TRIG_L1);
			2'h2: trig_level = CW'(TRIG_L2);
			default: trig_level = CW'(TRIG_L3);
		endcase
	endfunction

	// Parity bit for the active data bits
	function automatic logic par_bit(input logic [7:0] d,
		input logic [7:0] line_control_reg);
		logic [7:0] m;
		m = 8'hFF >> (3'h3 - line_control_reg[1:0]);
		if (line_control_reg[LCR_STICK_BIT])
			par_bit = ~line_control_reg[LCR_EVEN_BIT];
		else
			par_bit = line_control_reg[LCR_EVEN_BIT] ? ^(d & m) : ~^(d & m);
	endfunction

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [BUS_W-1:0] bus_meta_q;
	logic [BUS_W-1:0] bus_sync_q;
	logic rx_meta_q;
	logic rx_s_q;
	logic rx_prev_q;
	logic rd_act;
	logic wr_act;
	logic rd_act_q;
	logic wr_act_q;
	logic rd_done;
	logic wr_done;
	logic [2:0] cap_addr_q;
	logic [7:0] cap_data_q;
	logic [7:0] div_lo_q;
	logic [7:0] div_hi_q;
	logic [7:0] ier_q;
	logic [7:0] lcr_q;
	logic [7:0] mcr_q;
	logic [7:0] scr_q;
	logic fifo_en_q;
	logic [1:0] rx_trig_q;
	logic [1:0] tx_trig_q;
	logic dlab;
	logic wr_thr;
	logic wr_fcr;
	logic rd_rhr;
	logic rd_lsr;
	logic [1:0] presc_cnt_q;
	logic presc_tick;
	logic [15:0] div_cnt_q;
	logic [15:0] div_val;
	logic tick16;
	logic [2:0] ndata_m1;
	ubtc_txst_t tx_st_q;
	logic [3:0] tx_tick_q;
	logic [2:0] tx_bit_q;
	logic [7:0] tx_shift_q;
	logic tx_par_q;
	logic tx_level;
	logic serial_out_q;
	ubtc_rxst_t rx_st_q;
	logic [3:0] rx_tick_q;
	logic [2:0] rx_bit_q;
	logic [7:0] rx_shift_q;
	logic rx_par_q;
	logic rx_zero_q;
	logic rx_done;
	logic rx_room;
	logic [7:0] rx_byte;
	logic overrun_q;
	logic [TO_W-1:0] to_cnt_q;
	logic [TO_W-1:0] to_limit;
	logic rx_timeout;
	logic rx_int;
	logic tx_int;
	logic [3:0] isr_id;
	logic [7:0] line_status_reg;
	logic int_out_q;

	ubtc_fifo_if #(.W(8), .DEPTH(FIFO_DEPTH)) txf ();
	ubtc_fifo_if #(.W(11), .DEPTH(FIFO_DEPTH)) rxf ();

	ubtc_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo
	(
		.clk(clk),
		.rst(rst),
		.f(txf.store)
	);

	ubtc_fifo #(.W(11), .DEPTH(FIFO_DEPTH)) u_rx_fifo
	(
		.clk(clk),
		.rst(rst),
		.f(rxf.store)
	);

	// ****************************************************************
	// Pin synchronisers and strobe edges
	// ****************************************************************

	// Two-stage capture of host pins and serial input
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			bus_meta_q <= {BUS_W{1'b1}};
			bus_sync_q <= {BUS_W{1'b1}};
			rx_meta_q <= 1'b1;
			rx_s_q <= 1'b1;
			rx_prev_q <= 1'b1;
		end
		else
		begin
			bus_meta_q <= {cs_n, rd_n, wr_n, addr, data_in};
			bus_sync_q <= bus_meta_q;
			rx_meta_q <= serial_in;
			rx_s_q <= rx_meta_q;
			rx_prev_q <= rx_s_q;
		end
	end

	assign rd_act = ~bus_sync_q[13] & ~bus_sync_q[12];
	assign wr_act = ~bus_sync_q[13] & ~bus_sync_q[11];
	assign rd_done = rd_act_q & ~rd_act; // Strobe release
	assign wr_done = wr_act_q & ~wr_act;

	// Address and data sampled every clock while a strobe is active
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rd_act_q <= 1'b0;
			wr_act_q <= 1'b0;
			cap_addr_q <= 3'h0;
			cap_data_q <= 8'h00;
		end
		else
		begin
			rd_act_q <= rd_act;
			wr_act_q <= wr_act;
			if (rd_act | wr_act)
			begin
				cap_addr_q <= bus_sync_q[10:8];
				cap_data_q <= bus_sync_q[7:0];
			end
		end
	end

	// ****************************************************************
	// Register file
	// ****************************************************************
	assign dlab = lcr_q[LCR_DLAB_BIT];
	assign wr_thr = wr_done & (cap_addr_q == OFS_DATA) & ~dlab;
	assign wr_fcr = wr_done & (cap_addr_q == OFS_ISR_FCR);
	assign rd_rhr = rd_done & (cap_addr_q == OFS_DATA) & ~dlab;
	assign rd_lsr = rd_done & (cap_addr_q == OFS_LSR);

	// Control registers written at strobe release
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			div_lo_q <= DIV_LO_RST;
			div_hi_q <= DIV_HI_RST;
			ier_q <= REG_RST;
			lcr_q <= REG_RST;
			mcr_q <= REG_RST;
			scr_q <= REG_RST;
			fifo_en_q <= 1'b0;
			rx_trig_q <= 2'h0;
			tx_trig_q <= 2'h0;
		end
		else if (wr_done)
		begin
			unique case (cap_addr_q)
				OFS_DATA: if (dlab) div_lo_q <= cap_data_q;
				OFS_IER:
					if (dlab)
						div_hi_q <= cap_data_q;
					else
						ier_q <= cap_data_q;
				OFS_ISR_FCR:
				begin
					fifo_en_q <= cap_data_q[FCR_EN_BIT];
					tx_trig_q <= cap_data_q[5:4];
					rx_trig_q <= cap_data_q[7:6];
				end
				OFS_LCR: lcr_q <= cap_data_q;
				OFS_MCR: mcr_q <= cap_data_q;
				OFS_SCR: scr_q <= cap_data_q;
				default: ;
			endcase
		end
	end

	// FIFO resets on request or on mode change
	assign txf.clear = wr_fcr & (cap_data_q[FCR_TXRST_BIT]
		| (cap_data_q[FCR_EN_BIT] != fifo_en_q));
	assign rxf.clear = wr_fcr & (cap_data_q[FCR_RXRST_BIT]
		| (cap_data_q[FCR_EN_BIT] != fifo_en_q));

	// Status word
	assign line_status_reg = {1'b0,
		txf.empty & (tx_st_q == TX_IDLE),
		txf.empty,
		rxf.empty ? 3'h0 : rxf.rdata[10:8],
		overrun_q, ~rxf.empty};

	// Read data straight from pins and state, no clock needed
	always_comb
	begin
		data_out = 8'h00;
		unique case (addr)
			OFS_DATA: data_out = dlab ? div_lo_q : rxf.rdata[7:0];
			OFS_IER: data_out = dlab ? div_hi_q : ier_q;
			OFS_ISR_FCR: data_out = {fifo_en_q, fifo_en_q, 2'h0, isr_id};
			OFS_LCR: data_out = lcr_q;
			OFS_MCR: data_out = mcr_q;
			OFS_LSR: data_out = line_status_reg;
			OFS_SCR: data_out = scr_q;
			default: data_out = 8'h00;
		endcase
	end
	assign data_oe_n = cs_n | rd_n;

	// ****************************************************************
	// Baud generator
	// ****************************************************************
	assign div_val = {div_hi_q, div_lo_q};
	assign presc_tick = ~mcr_q[MCR_PRESC_BIT] | (presc_cnt_q == PRESC_LAST);
	assign tick16 = presc_tick
		& (({1'b0, div_cnt_q} + 17'h00001) >= {1'b0, div_val});

	// Prescaler and divisor counters
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			presc_cnt_q <= 2'h0;
			div_cnt_q <= 16'h0000;
		end
		else
		begin
			presc_cnt_q <= presc_cnt_q + 2'h1;
			if (tick16)
				div_cnt_q <= 16'h0000;
			else if (presc_tick)
				div_cnt_q <= div_cnt_q + 16'h0001;
		end
	end

	// ****************************************************************
	// Transmitter
	// ****************************************************************
	assign ndata_m1 = {1'b0, lcr_q[1:0]} + 3'h4;
	assign txf.push = wr_thr & (fifo_en_q ? ~txf.full : txf.empty);
	assign txf.wdata = cap_data_q;
	assign txf.pop = (tx_st_q == TX_IDLE) & ~txf.empty & tick16;

	// Frame sequencer
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tx_st_q <= TX_IDLE;
			tx_tick_q <= 4'h0;
			tx_bit_q <= 3'h0;
			tx_shift_q <= 8'h00;
			tx_par_q <= 1'b0;
		end
		else if (tx_st_q == TX_IDLE)
		begin
			if (~txf.empty & tick16) // Start on a tick: whole start bit
			begin
				tx_st_q <= TX_START;
				tx_shift_q <= txf.rdata;
				tx_par_q <= par_bit(txf.rdata, lcr_q);
				tx_tick_q <= 4'h0;
				tx_bit_q <= 3'h0;
			end
		end
		else if (tick16)
		begin
			tx_tick_q <= tx_tick_q + 4'h1;
			if (tx_tick_q == TICK_LAST)
			begin
				unique case (tx_st_q)
					TX_START: tx_st_q <= TX_DATA;
					TX_DATA:
					begin
						tx_shift_q <= tx_shift_q >> 1;
						if (tx_bit_q == ndata_m1)
						begin
							tx_bit_q <= 3'h0;
							tx_st_q <= lcr_q[LCR_PEN_BIT] ? TX_PARITY : TX_STOP;
						end
						else
							tx_bit_q <= tx_bit_q + 3'h1;
					end
					TX_PARITY: tx_st_q <= TX_STOP;
					TX_STOP:
						if (tx_bit_q == {2'h0, lcr_q[LCR_STOP_BIT]})
							tx_st_q <= TX_IDLE;
						else
							tx_bit_q <= tx_bit_q + 3'h1;
					default: tx_st_q <= TX_IDLE;
				endcase
			end
		end
	end

	// Line level per state
	always_comb
	begin
		tx_level = 1'b1;
		unique case (tx_st_q)
			TX_START: tx_level = 1'b0;
			TX_DATA: tx_level = tx_shift_q[0];
			TX_PARITY: tx_level = tx_par_q;
			default: tx_level = 1'b1;
		endcase
	end

	// Registered serial output
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			serial_out_q <= 1'b1;
		else
			serial_out_q <= tx_level;
	end
	assign serial_out = serial_out_q;

	// ****************************************************************
	// Receiver
	// ****************************************************************
	assign rx_done = (rx_st_q == RX_STOP) & tick16 & (rx_tick_q == TICK_LAST);
	assign rx_room = fifo_en_q ? ~rxf.full : rxf.empty;
	assign rx_byte = rx_shift_q >> (3'h7 - ndata_m1);
	assign rxf.push = rx_done & rx_room;
	assign rxf.wdata = {rx_zero_q & ~rx_s_q, ~rx_s_q,
		lcr_q[LCR_PEN_BIT] & (rx_par_q != par_bit(rx_byte, lcr_q)),
		rx_byte};
	assign rxf.pop = rd_rhr & ~rxf.empty;

	// Frame sampler
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rx_st_q <= RX_IDLE;
			rx_tick_q <= 4'h0;
			rx_bit_q <= 3'h0;
			rx_shift_q <= 8'h00;
			rx_par_q <= 1'b0;
			rx_zero_q <= 1'b0;
		end
		else if (rx_st_q == RX_IDLE)
		begin
			if (rx_prev_q & ~rx_s_q)
			begin
				rx_st_q <= RX_START;
				rx_tick_q <= 4'h0;
			end
		end
		else if (tick16)
		begin
			rx_tick_q <= rx_tick_q + 4'h1;
			if (rx_st_q == RX_START)
			begin
				if (rx_tick_q == TICK_HALF_LAST)
				begin
					rx_tick_q <= 4'h0;
					rx_bit_q <= 3'h0;
					rx_zero_q <= 1'b1;
					rx_st_q <= rx_s_q ? RX_IDLE : RX_DATA;
				end
			end
			else if (rx_tick_q == TICK_LAST)
			begin
				unique case (rx_st_q)
					RX_DATA:
					begin
						rx_shift_q <= {rx_s_q, rx_shift_q[7:1]};
						rx_zero_q <= rx_zero_q & ~rx_s_q;
						if (rx_bit_q == ndata_m1)
							rx_st_q <= lcr_q[LCR_PEN_BIT] ? RX_PARITY : RX_STOP;
						else
							rx_bit_q <= rx_bit_q + 3'h1;
					end
					RX_PARITY:
					begin
						rx_par_q <= rx_s_q;
						rx_zero_q <= rx_zero_q & ~rx_s_q;
						rx_st_q <= RX_STOP;
					end
					default: rx_st_q <= RX_IDLE;
				endcase
			end
		end
	end

	// Overrun flag, a new loss beats the status read
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			overrun_q <= 1'b0;
		else if (rx_done & ~rx_room)
			overrun_q <= 1'b1;
		else if (rd_lsr)
			overrun_q <= 1'b0;
	end

	// ****************************************************************
	// Receive timeout and interrupt output
	// ****************************************************************
	assign to_limit = TO_W'((TO_WORDS * (int'(ndata_m1) + 1) + TO_EXTRA_BITS)
		* TICKS_PER_BIT);
	assign rx_timeout = fifo_en_q & ~rxf.empty & (to_cnt_q >= to_limit);

	// Idle tick count while data waits
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			to_cnt_q <= '0;
		else if (rxf.push | rxf.pop | rxf.empty | ~fifo_en_q)
			to_cnt_q <= '0;
		else if (tick16 & (to_cnt_q < to_limit))
			to_cnt_q <= to_cnt_q + 1'b1;
	end

	assign rx_int = ier_q[IER_RX_BIT] & (fifo_en_q
		? (rxf.count >= trig_level(rx_trig_q)) : ~rxf.empty);
	assign tx_int = ier_q[IER_TX_BIT] & (fifo_en_q
		? (txf.count < trig_level(tx_trig_q))
		: txf.empty);

	// Source code by priority
	always_comb
	begin
		if (rx_timeout & ier_q[IER_RX_BIT])
			isr_id = ISR_TIMEOUT;
		else if (rx_int)
			isr_id = ISR_RX;
		else if (tx_int)
			isr_id = ISR_TX;
		else
			isr_id = ISR_NONE;
	end

	// Registered interrupt pin
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			int_out_q <= 1'b0;
		else
			int_out_q <= (isr_id != ISR_NONE);
	end
	assign int_out = int_out_q;

endmodule // ubtc_core
`default_nettype wire

// file: tb/ubtc_core_asserts.sv
// Checker for the serial core pins: bus enable, line framing, interrupt.
// Assumes binding onto ubtc_core with one clock domain.
`timescale 1ns/1ns
`default_nettype none
module ubtc_core_asserts
(
	input wire logic clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [2:0] addr,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic data_oe_n,
	input wire logic serial_in,
	input wire logic serial_out,
	input wire logic int_out
);
	// ****************************************************************
	// Helper state
	// ****************************************************************
	logic wr_seen_q;
	logic [15:0] lo_cnt_q;

	// Any host write since reset
	always_ff @(posedge clk or posedge rst)
		if (rst)
			wr_seen_q <= 1'b0;
		else if (!cs_n && !wr_n)
			wr_seen_q <= 1'b1;

	// Length of the current low run on the line
	always_ff @(posedge clk or posedge rst)
		if (rst)
			lo_cnt_q <= 16'h0000;
		else
			lo_cnt_q <= serial_out ? 16'h0000 : lo_cnt_q + 16'h0001;

	// ****************************************************************
	// Properties
	// ****************************************************************
	a_oe_follows_rd: assert property (@(posedge clk) disable iff (rst)
		data_oe_n == (cs_n | rd_n)) else $error("bus enable wrong");
	a_oe_off_write: assert property (@(posedge clk) disable iff (rst)
		(!wr_n && rd_n) |-> data_oe_n) else $error("bus driven on write");
	a_boot_line_idle: assert property (@(posedge clk) disable iff (rst)
		$fell(rst) |-> serial_out) else $error("line low after reset");
	a_boot_int_quiet: assert property (@(posedge clk) disable iff (rst)
		$fell(rst) |-> !int_out) else $error("interrupt after reset");
	a_tx_quiet_idle: assert property (@(posedge clk) disable iff (rst)
		!wr_seen_q |-> serial_out) else $error("frame without write");
	a_int_needs_write: assert property (@(posedge clk) disable iff (rst)
		!wr_seen_q |-> !int_out) else $error("interrupt without enable");
	a_bit_len_mult: assert property (@(posedge clk) disable iff (rst)
		$rose(serial_out) |-> lo_cnt_q[3:0] == 4'h0)
		else $error("low run not whole bits");
	a_bit_len_min: assert property (@(posedge clk) disable iff (rst)
		$rose(serial_out) |-> lo_cnt_q >= 16'h0010)
		else $error("low run under one bit");
endmodule // ubtc_core_asserts

bind ubtc_core ubtc_core_asserts i_chk (.clk, .rst, .cs_n, .rd_n, .wr_n,
	.addr, .data_in, .data_out, .data_oe_n, .serial_in, .serial_out,
	.int_out);
`default_nettype wire

// file: tb/ubtc_peer.sv
// Remote serial terminal: sends frames to the core, decodes its output.
// Assumes the bench sets bit length, word length and parity use.
`timescale 1ns/1ns
`default_nettype none
module ubtc_peer
(
	input wire logic clk,
	input wire logic from_dut,
	output logic to_dut
);
	int bit_clks = 16;
	int nbits = 8;
	logic par_on = 1'b0;
	logic [7:0] got;
	logic got_par;
	logic got_stop;
	int n_got = 0;

	initial to_dut = 1'b1;

	// Frame sender, LSB first, chosen stop level
	task automatic send(input logic [7:0] d, input logic par,
		input logic stop);
		int i;
		to_dut <= 1'b0;
		repeat (bit_clks) @(posedge clk);
		for (i = 0; i < nbits; i++)
		begin
			to_dut <= d[i];
			repeat (bit_clks) @(posedge clk);
		end
		if (par_on)
		begin
			to_dut <= par;
			repeat (bit_clks) @(posedge clk);
		end
		to_dut <= stop;
		repeat (bit_clks) @(posedge clk);
		to_dut <= 1'b1; // Marking level between frames
		repeat (bit_clks) @(posedge clk);
	endtask

	// Short low pulse shorter than half a bit
	task automatic glitch(input int n);
		to_dut <= 1'b0;
		repeat (n) @(posedge clk);
		to_dut <= 1'b1;
	endtask

	// Decoder sampling at bit centres
	initial
	forever
	begin
		@(negedge from_dut);
		got = 8'h00;
		repeat (bit_clks / 2) @(posedge clk);
		for (int i = 0; i < nbits; i++)
		begin
			repeat (bit_clks) @(posedge clk);
			got[i] = from_dut;
		end
		if (par_on)
		begin
			repeat (bit_clks) @(posedge clk);
			got_par = from_dut;
		end
		repeat (bit_clks) @(posedge clk);
		got_stop = from_dut;
		n_got++;
	end
endmodule // ubtc_peer
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the serial core and its host registers.
// Assumes the peer model on both serial lines and a 50 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module testbench
	import ubtc_pkg::*;
;
	typedef struct packed {
		logic [7:0] modem_control_reg;
		logic [7:0] div;
		logic [7:0] line_control_reg;
		logic [7:0] d;
	} ubtc_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cs_n = 1'b1;
	logic rd_n = 1'b1;
	logic wr_n = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] data_in = 8'h00;
	wire logic [7:0] data_out;
	wire logic data_oe_n;
	wire logic tx_line;
	wire logic rx_line;
	wire logic int_out;
	int err_count = 0;
	int n_tests = 0;
	int cyc = 0;
	logic [7:0] dm;
	logic par;
	ubtc_row_t rows [5] = '{
		'{8'h00, 8'h01, 8'h03, 8'hA5}, '{8'h00, 8'h01, 8'h00, 8'h15},
		'{8'h00, 8'h01, 8'h19, 8'h2D}, '{8'h00, 8'h03, 8'h0A, 8'h5B},
		'{8'h80, 8'h01, 8'h07, 8'hC3}};

	ubtc_core i_dut (.clk, .rst, .cs_n, .rd_n, .wr_n, .addr, .data_in,
		.data_out, .data_oe_n, .serial_in(rx_line), .serial_out(tx_line),
		.int_out);
	ubtc_peer i_peer (.clk, .from_dut(tx_line), .to_dut(rx_line));

	initial
	forever
		#10 clk = ~clk;

	// Hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			err_count++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] e,
		input logic [7:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_count++;
			$display("[ERR] %s exp %h got %h", what, e, g);
		end
	endtask

	// Host cycles: strobe held 4 clk, released 6 clk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		cs_n <= 1'b0;
		wr_n <= 1'b0;
		addr <= a;
		data_in <= d;
		repeat (4) @(posedge clk);
		cs_n <= 1'b1;
		wr_n <= 1'b1;
		repeat (6) @(posedge clk);
	endtask

	task automatic rchk(input logic [2:0] a, input logic [7:0] e,
		input string what);
		logic [7:0] d;
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		addr <= a;
		repeat (4) @(posedge clk);
		d = data_out;
		chk("bus enable", 8'h00, 8'(data_oe_n));
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		repeat (6) @(posedge clk);
		chk(what, e, d);
	endtask

	task automatic wait_tx(input int n);
		for (int k = 0; k < 3000 && i_peer.n_got < n; k++)
			@(posedge clk);
		chk("frame seen", 8'h01, 8'(i_peer.n_got >= n));
	endtask

	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		// Format rows, transmit then receive
		foreach (rows[r])
		begin
			wr(OFS_LCR, 8'h80);
			wr(OFS_DATA, rows[r].div);
			wr(OFS_IER, 8'h00);
			wr(OFS_LCR, rows[r].line_control_reg);
			wr(OFS_MCR, rows[r].modem_control_reg);
			i_peer.bit_clks = 16 * rows[r].div * (rows[r].modem_control_reg[7] ? 4 : 1);
			i_peer.nbits = 5 + rows[r].line_control_reg[1:0];
			i_peer.par_on = rows[r].line_control_reg[3];
			dm = rows[r].d & (8'hFF >> (3 - rows[r].line_control_reg[1:0]));
			par = rows[r].line_control_reg[4] ? ^dm : ~^dm;
			wr(OFS_DATA, rows[r].d);
			wait_tx(r + 1);
			chk("tx data", dm, i_peer.got);
			if (rows[r].line_control_reg[3])
				chk("tx parity", 8'(par), 8'(i_peer.got_par));
			chk("tx stop", 8'h01, 8'(i_peer.got_stop));
			i_peer.send(rows[r].d, par, 1'b1);
			rchk(OFS_LSR, 8'h61, "rx ready");
			rchk(OFS_DATA, dm, "rx data");
		end
		// Second reset in mid-run, then reset values
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		i_peer.bit_clks = 16;
		i_peer.nbits = 8;
		i_peer.par_on = 1'b0;
		repeat (2) @(posedge clk);
		rchk(OFS_LSR, 8'h60, "lsr reset");
		rchk(OFS_ISR_FCR, 8'h01, "isr reset");
		wr(OFS_LCR, 8'h80);
		rchk(OFS_DATA, DIV_LO_RST, "div low");
		rchk(OFS_IER, DIV_HI_RST, "div high");
		wr(OFS_LCR, 8'h03);
		// Single holding register
		wr(OFS_IER, 8'h02);
		chk("tx int", 8'h01, 8'(int_out));
		wr(OFS_DATA, 8'h3C);
		rchk(OFS_LSR, 8'h20, "lsr shifting");
		wait_tx(6);
		// Let the stop bit finish before looking at the idle flags
		repeat (16) @(posedge clk);
		rchk(OFS_LSR, 8'h60, "lsr sent");
		// FIFO burst, order kept
		wr(OFS_ISR_FCR, 8'h41);
		wr(OFS_DATA, 8'h11);
		wr(OFS_DATA, 8'h22);
		wr(OFS_DATA, 8'h33);
		rchk(OFS_LSR, 8'h00, "lsr fifo busy");
		chk("tx fifo int", 8'h00, 8'(int_out));
		for (int k = 0; k < 3; k++)
		begin
			wait_tx(7 + k);
			chk("fifo order", 8'(8'h11 * (k + 1)), i_peer.got);
		end
		repeat (16) @(posedge clk);
		rchk(OFS_LSR, 8'h60, "lsr fifo done");
		chk("tx fifo int", 8'h01, 8'(int_out));
		// Framing tag, trigger defer, timeout
		wr(OFS_IER, 8'h01);
		i_peer.send(8'h5A, 1'b0, 1'b0);
		i_peer.send(8'h6B, 1'b0, 1'b1);
		chk("rx int deferred", 8'h00, 8'(int_out));
		repeat (720) @(posedge clk);
		chk("timeout int", 8'h01, 8'(int_out));
		rchk(OFS_ISR_FCR, 8'hCC, "isr timeout");
		rchk(OFS_LSR, 8'h69, "frame tag");
		rchk(OFS_DATA, 8'h5A, "rx first");
		rchk(OFS_LSR, 8'h61, "next tag");
		rchk(OFS_DATA, 8'h6B, "rx second");
		// Break: zero data and low stop bit
		i_peer.send(8'h00, 1'b0, 1'b0);
		rchk(OFS_LSR, 8'h79, "break tag");
		rchk(OFS_DATA, 8'h00, "rx break");
		// Pulse too short for a start bit, wait past a whole frame
		i_peer.glitch(4);
		repeat (200) @(posedge clk);
		rchk(OFS_LSR, 8'h60, "false start");
		tally_and_finish();
	end
endmodule // testbench
`default_nettype wire
